//--- rtl/fcg_pkg.sv
// Constants, register indices and carrier types for the frame checker
// and frame generator. Assumes one 125 MHz clock and word-wide
// Avalon-MM register access where byte address = 4 x register index.
package fcg_pkg;
  // Register indices.
  localparam logic [15:0] IDX_RX_ERR   = 16'h8008;
  localparam logic [15:0] IDX_OSZ      = 16'h800e;
  localparam logic [15:0] IDX_USZ      = 16'h800f;
  localparam logic [15:0] IDX_ODD      = 16'h8010;
  localparam logic [15:0] IDX_PRE      = 16'h8011;
  localparam logic [15:0] IDX_FCR      = 16'h8013;
  localparam logic [15:0] IDX_GEN_EN   = 16'h8020;
  localparam logic [15:0] IDX_GEN_CTL  = 16'h8021;
  localparam logic [15:0] IDX_GEN_CONT = 16'h8022;
  localparam logic [15:0] IDX_NFRM_H   = 16'h8027;
  localparam logic [15:0] IDX_NFRM_L   = 16'h8028;
  localparam logic [15:0] IDX_DONE     = 16'h8029;
  localparam logic [15:0] IDX_DIAG     = 16'h8030;
  localparam int          ADDR_W       = 18;
  // Field positions and reset values.
  localparam int          CTL_RESTART  = 3;
  localparam logic [2:0]  PAT_STOP     = 3'h0;
  localparam logic [2:0]  PAT_RAND     = 3'h1;
  localparam logic [2:0]  PAT_ZERO     = 3'h2;
  localparam logic [2:0]  PAT_ONES     = 3'h3;
  localparam logic [2:0]  PAT_55       = 3'h4;
  localparam logic [2:0]  PAT_DEC      = 3'h5;
  localparam logic [2:0]  CTL_RESET    = PAT_RAND;
  localparam logic [15:0] NFRM_H_RESET = 16'h0000;
  localparam logic [15:0] NFRM_L_RESET = 16'h0100;
  // Checker limits and generator shape.
  localparam logic [15:0] MAX_FRAME    = 16'd1522;
  localparam logic [15:0] MIN_FRAME    = 16'd64;
  localparam logic [15:0] GEN_LEN      = 16'h006b;
  localparam logic [15:0] GAP_LEN      = 16'h000c;
  localparam logic [7:0]  LFSR_SEED    = 8'h01;
  localparam logic [7:0]  BYTE_55      = 8'h55;
  localparam logic [7:0]  DEC_START    = 8'hff;
  localparam int          NUM_CNT      = 5;
  localparam int          FIFO_W       = 9;
  localparam int          FIFO_D       = 16;
  // Receive events, all one-cycle strobes from the receive datapath.
  typedef struct packed {
    logic        frame_end;
    logic [15:0] bytes;
    logic        odd_nibble;
    logic        odd_preamble;
    logic        bad_ssd;
    logic        rx_error;
  } rx_event_t;
  // One transmit byte with its end-of-frame mark.
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tx_byte_t;
  typedef enum logic [1:0] {
    GEN_IDLE  = 2'b00,
    GEN_FRAME = 2'b01,
    GEN_GAP   = 2'b11
  } gen_state_t;
endpackage : fcg_pkg

//--- rtl/fcg_top.sv
// Frame checker counters, frame generator, transmit source select and
// the transmit FIFO, with Avalon-MM register access.
// Assumes receive events and MAC bytes come from logic on MCLK.
`timescale 1ns/1ps
module fcg_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Fill side.
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side.
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Flags come from the fill count, so full and empty never lie.
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + AW'(push);
      rd_q  <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // One entry per generate step; storage needs no reset.
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (push && wr_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule : fcg_fifo

module fcg_top (
  // Clock and reset.
  input  wire logic                     MCLK,
  input  wire logic                     RST_B,
  // Avalon-MM register slave.
  input  wire logic [fcg_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  output logic [31:0]                   AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  // Receive events.
  input  wire fcg_pkg::rx_event_t       RX_EVENT,
  // MAC transmit bytes.
  input  wire fcg_pkg::tx_byte_t        MAC_TX,
  input  wire logic                     MAC_TX_VALID,
  output logic                          MAC_TX_READY,
  // PHY transmit bytes.
  output fcg_pkg::tx_byte_t             PHY_TX,
  output logic                          PHY_TX_VALID,
  input  wire logic                     PHY_TX_READY
);
  localparam int N = fcg_pkg::NUM_CNT;

  // Bus state and software registers.
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        gen_en_q;
  logic [2:0]  pattern_q;
  logic        restart_q;
  logic        cont_q;
  logic [15:0] nfrm_h_q;
  logic [15:0] nfrm_l_q;
  logic        done_q;
  logic        diag_q;
  logic [15:0] tally_q;
  logic [15:0] live_q [N];
  logic [15:0] copy_q [N];
  // Generator state.
  fcg_pkg::gen_state_t state_q;
  fcg_pkg::gen_state_t state_d;
  logic [15:0] idx_q;
  logic [15:0] gap_q;
  logic [31:0] remain_q;
  logic [7:0]  lfsr_q;
  logic        run_q;
  logic        sel_q;

  // Merge a write into a 16-bit register by byte lane.
  function automatic logic [15:0] merge(input logic [15:0] cur,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
  endfunction : merge

  // Decode: a read acts at the first edge, a write at the completing one.
  wire [15:0] idx     = AVS_ADDRESS[fcg_pkg::ADDR_W-1:2];
  wire        rd_fire = AVS_READ & wait_q;
  wire        wr_fire = AVS_WRITE & ~wait_q;
  wire        lo_wr   = wr_fire & AVS_BYTEENABLE[0];
  wire        hit_err = (idx == fcg_pkg::IDX_RX_ERR);
  wire        hit_en  = (idx == fcg_pkg::IDX_GEN_EN);
  wire        hit_ctl = (idx == fcg_pkg::IDX_GEN_CTL);
  wire        hit_cnt = (idx == fcg_pkg::IDX_GEN_CONT);
  wire        hit_nh  = (idx == fcg_pkg::IDX_NFRM_H);
  wire        hit_nl  = (idx == fcg_pkg::IDX_NFRM_L);
  wire        hit_dn  = (idx == fcg_pkg::IDX_DONE);
  wire        hit_dg  = (idx == fcg_pkg::IDX_DIAG);
  wire        latch   = rd_fire & hit_err;

  // Read multiplexer; unmapped addresses and reserved bits read zero.
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_err) begin
      rd_mux = tally_q;
    end else if (idx == fcg_pkg::IDX_OSZ) begin
      rd_mux = copy_q[0];
    end else if (idx == fcg_pkg::IDX_USZ) begin
      rd_mux = copy_q[1];
    end else if (idx == fcg_pkg::IDX_ODD) begin
      rd_mux = copy_q[2];
    end else if (idx == fcg_pkg::IDX_PRE) begin
      rd_mux = copy_q[3];
    end else if (idx == fcg_pkg::IDX_FCR) begin
      rd_mux = copy_q[4];
    end else if (hit_en) begin
      rd_mux = {15'h0000, gen_en_q};
    end else if (hit_ctl) begin
      rd_mux = {13'h0000, pattern_q};
    end else if (hit_cnt) begin
      rd_mux = {15'h0000, cont_q};
    end else if (hit_nh) begin
      rd_mux = nfrm_h_q;
    end else if (hit_nl) begin
      rd_mux = nfrm_l_q;
    end else if (hit_dn) begin
      rd_mux = {15'h0000, done_q};
    end else if (hit_dg) begin
      rd_mux = {15'h0000, diag_q};
    end
  end

  // Waitrequest drops for exactly one cycle after a request appears.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~((AVS_READ | AVS_WRITE) & wait_q);
      if (rd_fire) begin
        rdata_q <= {16'h0000, rd_mux};
      end
    end
  end

  // Software control registers; only defined bits are stored.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      gen_en_q  <= 1'b0;
      pattern_q <= fcg_pkg::CTL_RESET;
      restart_q <= 1'b0;
      cont_q    <= 1'b0;
      nfrm_h_q  <= fcg_pkg::NFRM_H_RESET;
      nfrm_l_q  <= fcg_pkg::NFRM_L_RESET;
      diag_q    <= 1'b0;
    end else begin
      // The restart bit lives one cycle, so it always reads back zero.
      restart_q <= lo_wr & hit_ctl &
                   AVS_WRITEDATA[fcg_pkg::CTL_RESTART];
      if (lo_wr && hit_en) begin
        gen_en_q <= AVS_WRITEDATA[0];
      end
      if (lo_wr && hit_ctl) begin
        pattern_q <= AVS_WRITEDATA[2:0];
      end
      if (lo_wr && hit_cnt) begin
        cont_q <= AVS_WRITEDATA[0];
      end
      if (lo_wr && hit_dg) begin
        diag_q <= AVS_WRITEDATA[0];
      end
      if (wr_fire && hit_nh) begin
        nfrm_h_q <= merge(nfrm_h_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (wr_fire && hit_nl) begin
        nfrm_l_q <= merge(nfrm_l_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  // Checker events. Lengths are judged only at the end of a frame.
  wire         fe = RX_EVENT.frame_end;
  wire [N-1:0] inc = {
    RX_EVENT.bad_ssd,
    fe & RX_EVENT.odd_preamble,
    fe & RX_EVENT.odd_nibble,
    fe & (RX_EVENT.bytes < fcg_pkg::MIN_FRAME),
    fe & (RX_EVENT.bytes > fcg_pkg::MAX_FRAME)
  };
  wire         err_ev = RX_EVENT.rx_error | (fe & (|inc[3:0]));

  // Live counters run freely; copies move only on a tally read.
  for (genvar c = 0; c < N; c++) begin : g_cnt
    always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
        live_q[c] <= 16'h0000;
        copy_q[c] <= 16'h0000;
      end else begin
        live_q[c] <= live_q[c] + 16'(inc[c]);
        if (latch) begin
          copy_q[c] <= live_q[c];
        end
      end
    end
  end

  // The tally clears on read, but an error in that cycle still counts.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tally_q <= 16'h0000;
    end else if (latch) begin
      tally_q <= 16'(err_ev);
    end else begin
      tally_q <= tally_q + 16'(err_ev);
    end
  end

  // Generator triggers. Without the diagnostic clock nothing runs.
  wire        run      = gen_en_q & diag_q;
  wire        start    = run & ((~run_q) | restart_q);
  wire [31:0] load     = {nfrm_h_q, nfrm_l_q};
  wire        pat_ok   = (pattern_q != fcg_pkg::PAT_STOP) &
                         (pattern_q <= fcg_pkg::PAT_DEC);
  wire        fifo_rdy;
  wire        gen_push = (state_q == fcg_pkg::GEN_FRAME);
  wire        accept   = gen_push & fifo_rdy;
  wire        last     = (idx_q == fcg_pkg::GEN_LEN - 16'd1);
  wire        fr_done  = accept & last;
  wire        zero_go  = start & ~cont_q & (load == 32'h0000_0000);
  wire        burst_end = fr_done & ~cont_q &
                          (remain_q == 32'h0000_0001);
  wire        gap_end  = (gap_q == fcg_pkg::GAP_LEN - 16'd1);

  // Data field pattern for the current byte.
  logic [7:0] gen_byte;
  always_comb begin
    gen_byte = 8'h00;
    case (pattern_q)
      fcg_pkg::PAT_RAND: gen_byte = lfsr_q;
      fcg_pkg::PAT_ONES: gen_byte = 8'hff;
      fcg_pkg::PAT_55:   gen_byte = fcg_pkg::BYTE_55;
      fcg_pkg::PAT_DEC:  gen_byte = fcg_pkg::DEC_START - idx_q[7:0];
      default:           gen_byte = 8'h00;
    endcase
  end

  // Generator sequence: frame, then idle after a burst's last frame, else gap then either another frame or idle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcg_pkg::GEN_IDLE: begin
        if (start && pat_ok && !zero_go) begin
          state_d = fcg_pkg::GEN_FRAME;
        end
      end
      fcg_pkg::GEN_FRAME: begin
        // A frame once begun always runs to its end.
        if (burst_end && !start) begin
          state_d = fcg_pkg::GEN_IDLE;
        end else if (fr_done) begin
          state_d = fcg_pkg::GEN_GAP;
        end
      end
      fcg_pkg::GEN_GAP: begin
        if (gap_end) begin
          if (run && pat_ok) begin
            state_d = fcg_pkg::GEN_FRAME;
          end else begin
            state_d = fcg_pkg::GEN_IDLE;
          end
        end
      end
      default: state_d = fcg_pkg::GEN_IDLE;
    endcase
  end

  // Generator registers.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q  <= fcg_pkg::GEN_IDLE;
      idx_q    <= 16'h0000;
      gap_q    <= 16'h0000;
      remain_q <= 32'h0000_0000;
      lfsr_q   <= fcg_pkg::LFSR_SEED;
      run_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      run_q   <= run;
      if (accept) begin
        idx_q  <= last ? 16'h0000 : idx_q + 16'd1;
        lfsr_q <= {lfsr_q[6:0],
                   lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      end
      gap_q <= (state_q == fcg_pkg::GEN_GAP) ? gap_q + 16'd1 : 16'h0000;
      if (start) begin
        remain_q <= load;
      end else if (fr_done && !cont_q) begin
        remain_q <= remain_q - 32'd1;
      end
    end
  end

  // Done latches high until read; a completion on the read edge wins.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      done_q <= 1'b0;
    end else if ((burst_end && !start) || zero_go) begin
      done_q <= 1'b1;
    end else if (rd_fire && hit_dn) begin
      done_q <= 1'b0;
    end
  end

  // Source select holds on the generator while it runs and until it is back in idle.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= run | (state_d != fcg_pkg::GEN_IDLE);
    end
  end

  // Transmit source multiplexer into the FIFO.
  fcg_pkg::tx_byte_t gen_tx;
  fcg_pkg::tx_byte_t fifo_in;
  fcg_pkg::tx_byte_t fifo_out;
  assign gen_tx.last  = last;
  assign gen_tx.data  = gen_byte;
  assign fifo_in      = sel_q ? gen_tx : MAC_TX;
  wire   fifo_vld     = sel_q ? gen_push : MAC_TX_VALID;
  assign MAC_TX_READY = ~sel_q & fifo_rdy;

  // The PHY stalls the FIFO, and a full FIFO stalls both sources.
  fcg_fifo #(
    .W (fcg_pkg::FIFO_W),
    .D (fcg_pkg::FIFO_D)
  ) u_fifo (
    .clk       (MCLK),
    .rst_b     (RST_B),
    .in_data   (fifo_in),
    .in_valid  (fifo_vld),
    .in_ready  (fifo_rdy),
    .out_data  (fifo_out),
    .out_valid (PHY_TX_VALID),
    .out_ready (PHY_TX_READY)
  );
  assign PHY_TX          = fifo_out;
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
endmodule : fcg_top

//--- tb/fcg_top_assertions.sv
// Concurrent checks on the register bus, source select and stream.
// Bound to fcg_top from the bench; sees only the top module's ports.
`timescale 1ns/1ps
module fcg_top_assertions (
  // Clock and reset.
  input logic                       MCLK,
  input logic                       RST_B,
  // Register bus.
  input logic [fcg_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input logic                       AVS_READ,
  input logic                       AVS_WRITE,
  input logic [31:0]                AVS_WRITEDATA,
  input logic [3:0]                 AVS_BYTEENABLE,
  input logic [31:0]                AVS_READDATA,
  input logic                       AVS_WAITREQUEST,
  // Streams.
  input fcg_pkg::rx_event_t         RX_EVENT,
  input fcg_pkg::tx_byte_t          MAC_TX,
  input logic                       MAC_TX_VALID,
  input logic                       MAC_TX_READY,
  input fcg_pkg::tx_byte_t          PHY_TX,
  input logic                       PHY_TX_VALID,
  input logic                       PHY_TX_READY
);
  logic       en_q, cont_q, diag_q;
  // Decode of completed accesses; a write lands at its answer edge.
  wire [15:0] idx    = AVS_ADDRESS[17:2];
  wire        rd_ack = AVS_READ && !AVS_WAITREQUEST;
  wire        wr_ack = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire        run    = en_q && diag_q;
  // Mirror of the one-bit controls, kept from the bus traffic alone.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      en_q   <= 1'b0;
      cont_q <= 1'b0;
      diag_q <= 1'b0;
    end else if (wr_ack) begin
      if (idx == fcg_pkg::IDX_GEN_EN) en_q <= AVS_WRITEDATA[0];
      if (idx == fcg_pkg::IDX_GEN_CONT) cont_q <= AVS_WRITEDATA[0];
      if (idx == fcg_pkg::IDX_DIAG) diag_q <= AVS_WRITEDATA[0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // A request waits one cycle, is answered for one cycle, then rests.
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  a_ack_once: assert property (s_req |=> s_ack)
    else $error("request not answered for exactly one cycle");
  a_ack_cause: assert property (!AVS_WAITREQUEST |->
    $past((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST))
    else $error("answer without a pending request");
  a_upper_zero: assert property (rd_ack |->
    AVS_READDATA[31:16] == 16'h0) else $error("upper read half not zero");
  a_unmapped_zero: assert property (
    rd_ack && idx[15:6] != 10'h200 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_enable_mirror: assert property (
    rd_ack && idx == fcg_pkg::IDX_GEN_EN |-> AVS_READDATA == {31'h0, en_q})
    else $error("enable reads back wrong");
  a_cont_mirror: assert property (
    rd_ack && idx == fcg_pkg::IDX_GEN_CONT |->
    AVS_READDATA == {31'h0, cont_q}) else $error("mode reads back wrong");
  a_ctl_restart: assert property (
    rd_ack && idx == fcg_pkg::IDX_GEN_CTL |-> AVS_READDATA[15:3] == 13'h0)
    else $error("restart or reserved bits read as set");
  a_mac_block: assert property (
    run && $past(run) && $past(run, 2) |-> !MAC_TX_READY)
    else $error("MAC accepted while generator selected");
  a_tx_hold: assert property (
    PHY_TX_VALID && !PHY_TX_READY |=> PHY_TX_VALID && $stable(PHY_TX))
    else $error("offered byte changed before taken");
endmodule : fcg_top_assertions

//--- tb/fcg_phy_sink.sv
// Model of the PHY transmit path that takes bytes from the block.
// Assumes the block's clock; stalls on command or at random.
`timescale 1ns/1ps
module fcg_phy_sink (
  // Clock and reset.
  input  logic clk,
  input  logic rst_b,
  // Pacing from the bench.
  input  logic stall,
  input  logic slow,
  // Pop strobe to the block.
  output logic ready
);
  int seed = 62;
  // Ready moves only after an edge, so no byte is half taken.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) ready <= 1'b0;
    else ready <= !stall && (!slow || ($random(seed) & 3) != 0);
  end
endmodule : fcg_phy_sink

//--- tb/tb_fcg_top.sv
// Self-checking bench: registers, checker copies, MAC path, FIFO fill,
// generator bursts, restart and continuous mode.
// Assumes the package, the design, the checker and the sink model.
`timescale 1ns/1ps
module tb_fcg_top;
  logic                         mclk, rst_b, avs_read, avs_write, avs_wait;
  logic [fcg_pkg::ADDR_W-1:0]   avs_addr;
  logic [31:0]                  avs_wdata, avs_rdata, last_rd, rq[$];
  logic                         mac_valid, mac_ready, phy_valid, phy_ready;
  logic                         stall, slow, chk_on;
  fcg_pkg::rx_event_t           rx_ev;
  fcg_pkg::tx_byte_t            mac_tx, phy_tx, tq[$];
  int                           errors, num_checks, cycles, nbytes, nframes;
  int                           seed = 62;
  int                           len = fcg_pkg::GEN_LEN;
  logic [15:0] ri [12] = '{fcg_pkg::IDX_OSZ, fcg_pkg::IDX_USZ,
    fcg_pkg::IDX_ODD, fcg_pkg::IDX_PRE, fcg_pkg::IDX_FCR, fcg_pkg::IDX_GEN_EN,
    fcg_pkg::IDX_GEN_CTL, fcg_pkg::IDX_GEN_CONT, fcg_pkg::IDX_NFRM_H,
    fcg_pkg::IDX_NFRM_L, fcg_pkg::IDX_DONE, 16'h8012};
  logic [15:0] re [12] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 16'h0100, 0, 0};
  logic [15:0] rb [8]  = '{1523, 1522, 63, 64, 100, 100, 0, 0};
  logic [2:0]  rf [8]  = '{0, 0, 0, 0, 4, 2, 1, 1};
  logic [15:0] ci [5]  = '{fcg_pkg::IDX_OSZ, fcg_pkg::IDX_USZ,
    fcg_pkg::IDX_ODD, fcg_pkg::IDX_PRE, fcg_pkg::IDX_FCR};
  logic [31:0] ce [5]  = '{1, 1, 1, 1, 2};

  fcg_top dut (.MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(avs_addr),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_wdata),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_rdata),
    .AVS_WAITREQUEST(avs_wait), .RX_EVENT(rx_ev), .MAC_TX(mac_tx),
    .MAC_TX_VALID(mac_valid), .MAC_TX_READY(mac_ready), .PHY_TX(phy_tx),
    .PHY_TX_VALID(phy_valid), .PHY_TX_READY(phy_ready));
  fcg_phy_sink sink (.clk(mclk), .rst_b(rst_b), .stall(stall), .slow(slow),
    .ready(phy_ready));

  // Free-running clock at 125 MHz.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One bus access; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [15:0] d);
    int n;
    n = 0;
    avs_addr  <= {i, 2'b00};
    avs_wdata <= {16'h0, d};
    avs_write <= w;
    avs_read  <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_wait !== 1'b0 && n < 100);
    if (n >= 100) check(32'h0, 32'h1);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    bus(1'b1, i, d);
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, i, 16'h0);
  endtask : rd

  // Polling clears the flag, so the poll itself is the one reader.
  task automatic wait_done();
    last_rd = 32'h0;
    for (int k = 0; k < 400 && last_rd[0] !== 1'b1; k++)
      bus(1'b0, fcg_pkg::IDX_DONE, 16'h0);
    check(last_rd, 32'h1);
  endtask : wait_done

  task automatic rx(input logic [15:0] b, input logic [2:0] f);
    rx_ev <= {b != 16'h0, b, f, 1'b0};
    @(posedge mclk);
    rx_ev <= '0;
    @(posedge mclk);
  endtask : rx

  // Offer n random MAC bytes, the last one marked, and note each taken.
  task automatic mac(input int n);
    fcg_pkg::tx_byte_t b;
    int k;
    for (int i = 0; i < n; i++) begin
      b = {i == n - 1, 8'($random(seed))};
      mac_tx    <= b;
      mac_valid <= 1'b1;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (mac_ready !== 1'b1 && k < 100);
      tq.push_back(b);
    end
    mac_valid <= 1'b0;
    @(posedge mclk);
  endtask : mac

  task automatic expect_frame(input logic [2:0] p);
    for (int i = 0; i < len; i++)
      tq.push_back({i == len - 1, p == 3'h2 ? 8'h00 : p == 3'h3 ? 8'hff :
                    p == 3'h4 ? 8'h55 : 8'(255 - i)});
  endtask : expect_frame

  // Match each noted read, and each PHY byte while chk_on is set, to the oldest note as it appears.
  always @(posedge mclk) begin
    if (avs_read && avs_wait === 1'b0) begin
      last_rd = avs_rdata;
      if (rq.size() > 0) check(avs_rdata, rq.pop_front());
    end
    if (phy_valid === 1'b1 && phy_ready) begin
      nbytes++;
      nframes += phy_tx.last;
      if (chk_on) check(phy_tx, tq.size() > 0 ? tq.pop_front() : 'x);
    end
  end

  // A hang is cut short well past the expected length of the run.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      check(32'h0, 32'h1);
      conclude();
    end
  end

  initial begin
    int b0, b1, f0;
    {rst_b, avs_read, avs_write, mac_valid, stall, slow} = '0;
    {avs_addr, avs_wdata, rx_ev, mac_tx} = '0;
    chk_on = 1'b1;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 12; i++) rd(ri[i], re[i]);
    rd(16'h4012, 32'h0);
    wr(fcg_pkg::IDX_GEN_CONT, 16'hffff);
    rd(fcg_pkg::IDX_GEN_CONT, 32'h1);
    wr(fcg_pkg::IDX_GEN_CONT, 16'h0);
    wr(fcg_pkg::IDX_NFRM_H, 16'h1234);
    rd(fcg_pkg::IDX_NFRM_H, 32'h1234);
    wr(fcg_pkg::IDX_NFRM_H, 16'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) rx(rb[i], rf[i]);
    rd(fcg_pkg::IDX_OSZ, 32'h0);
    rd(fcg_pkg::IDX_RX_ERR, 32'h4);
    for (int i = 0; i < 5; i++) rd(ci[i], ce[i]);
    rd(fcg_pkg::IDX_RX_ERR, 32'h0);
    $display("test checker counts done");
    wr(fcg_pkg::IDX_GEN_EN, 16'h1);
    repeat (20) @(posedge mclk);
    check(mac_ready, 1'b1);
    check(phy_valid, 1'b0);
    wr(fcg_pkg::IDX_GEN_EN, 16'h0);
    stall <= 1'b1;
    mac(16);
    check(mac_ready, 1'b0);
    stall <= 1'b0;
    slow  <= 1'b1;
    mac(8);
    for (int k = 0; k < 3000 && tq.size() > 0; k++) @(posedge mclk);
    // The last pop settles only after the edge that takes it.
    @(posedge mclk);
    check(phy_valid, 1'b0);
    $display("test MAC path and fill done");
    wr(fcg_pkg::IDX_DIAG, 16'h1);
    for (int p = 2; p <= 5; p++) begin
      wr(fcg_pkg::IDX_GEN_EN, 16'h0);
      wr(fcg_pkg::IDX_GEN_CTL, 16'(p));
      wr(fcg_pkg::IDX_NFRM_L, 16'(p - 1));
      repeat (p - 1) expect_frame(3'(p));
      wr(fcg_pkg::IDX_GEN_EN, 16'h1);
      wait_done();
      rd(fcg_pkg::IDX_DONE, 32'h0);
      $display("test pattern %0d done", p);
    end
    repeat (4) expect_frame(3'h5);
    wr(fcg_pkg::IDX_GEN_CTL, 16'h000d);
    wait_done();
    rd(fcg_pkg::IDX_GEN_CTL, 32'h5);
    for (int k = 0; k < 9000 && tq.size() > 0; k++) @(posedge mclk);
    check(tq.size(), 0);
    $display("test restart done");
    chk_on = 1'b0;
    wr(fcg_pkg::IDX_GEN_EN, 16'h0);
    wr(fcg_pkg::IDX_GEN_CONT, 16'h1);
    wr(fcg_pkg::IDX_GEN_CTL, 16'h1);
    wr(fcg_pkg::IDX_NFRM_L, 16'h1);
    b0 = nbytes;
    f0 = nframes;
    wr(fcg_pkg::IDX_GEN_EN, 16'h1);
    for (int k = 0; k < 3000 && nframes - f0 < 3; k++) @(posedge mclk);
    wr(fcg_pkg::IDX_GEN_CTL, 16'h0);
    repeat (400) @(posedge mclk);
    b1 = nbytes;
    check((b1 - b0) % len, 0);
    repeat (300) @(posedge mclk);
    check(nbytes, b1);
    check(nframes - f0 >= 3, 1'b1);
    $display("test continuous done");
    wr(fcg_pkg::IDX_GEN_EN, 16'h0);
    wr(fcg_pkg::IDX_GEN_CONT, 16'h0);
    wr(fcg_pkg::IDX_GEN_CTL, 16'h2);
    wr(fcg_pkg::IDX_NFRM_L, 16'h0);
    wr(fcg_pkg::IDX_GEN_EN, 16'h1);
    wait_done();
    repeat (50) @(posedge mclk);
    check(nbytes, b1);
    $display("test empty burst done");
    conclude();
  end
endmodule : tb_fcg_top

bind fcg_top fcg_top_assertions chk (.MCLK, .RST_B, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
  .AVS_WAITREQUEST, .RX_EVENT, .MAC_TX, .MAC_TX_VALID, .MAC_TX_READY,
  .PHY_TX, .PHY_TX_VALID, .PHY_TX_READY);
